// ### hdl/output_compare_channel.sv
// Output compare channel with APB register slave and interrupt
//
// Functional notes
// - Mode 000 disables channel, no output activity
// - Mode 001 starts low, match drives high
// - Mode 010 starts high, match drives low
// - Mode 011 toggles output on every primary match
// - Mode 100 one pulse on primary/secondary matches
// - Mode 101 continuous pulses on alternate matches
// - Mode 110 edge PWM, 111 center PWM
// - Trigger status cleared by secondary match optionally
// - Fault A sets sticky fault-0 status
// - Fault enable/status only act in PWM modes
// - Comparator group selects this channel's comparator
// - Output and faults pass through pin-select enables
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps

module output_compare_channel
  import ocmp_pkg::*;
#(
  parameter int channel_index = 1,
  parameter int timer_width   = 16
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Faults, comparators and pin select
  input  wire logic        fault_a_input,
  input  wire logic        fault_b_input,
  input  wire logic [2:0]  comparator_out,
  input  wire logic        output_pin_assigned,
  input  wire logic        fault_pin_assigned,
  // Compare pin and interrupt
  output logic             compare_output_pin,
  output logic             irq
);

  // Counter is 1 to 16 bits wide; comparator groups cover nine channels
  if (timer_width < 1 || timer_width > 16) begin : g_bad_width
    $error("timer_width must be 1 to 16");
  end
  if (channel_index < 1 || channel_index > 9) begin : g_bad_channel
    $error("channel_index must be 1 to 9");
  end

  typedef struct packed {
    logic [15:0] compare_control_one;
    logic [15:0] compare_control_two;
    logic [15:0] primary_compare_value;
    logic [15:0] secondary_compare_value;
    logic [15:0] compare_timer;
    logic        out_level;
    logic        shot_done;
    logic        pulse_phase;
    logic        count_down;
    logic        trigger_status;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        pin;
    logic        irq_line;
  } state_t;

  state_t cur;
  state_t next_state;

  // Comparator feeding this channel's group of three
  function automatic logic group_comparator(input logic [2:0] cmp);
    int grp;
    grp = (channel_index - 1) / 3;
    return cmp[grp[1:0]];
  endfunction

  function automatic logic is_pwm(input logic [2:0] m);
    return m[2] & m[1];
  endfunction

  logic [2:0]  mode;
  logic        pri_match;
  logic        sec_match;
  logic        fault_seen;
  logic        wr;
  logic        rd;
  logic [15:0] tmax;
  logic        mode_write;

  assign mode       = cur.compare_control_one[mode_lsb +: 3];
  assign tmax       = 16'((32'h1 << timer_width) - 1);
  assign pri_match  = (cur.compare_timer == cur.primary_compare_value);
  assign sec_match  = (cur.compare_timer == cur.secondary_compare_value);
  assign wr = psel & penable & pwrite & ~cur.ready;
  assign rd = psel & penable & ~pwrite & ~cur.ready;
  assign mode_write = wr & (paddr == ctrl_one_addr);

  // Fault only counted with pins mapped and a PWM mode selected
  assign fault_seen = fault_pin_assigned & is_pwm(mode)
                    & cur.compare_control_one[fault_en_bit]
                    & (fault_a_input | group_comparator(comparator_out));

  always_comb begin
    next_state = cur;
    next_state.ready  = 1'b0;
    next_state.slverr = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // Timer: free counting, cleared on secondary match in edge PWM, up/down in center PWM
    if (cur.compare_control_one[timer_en_bit] && mode != mode_off) begin
      if (mode == mode_pwm_center) begin
        if (!cur.count_down) begin
          if (cur.compare_timer >= cur.secondary_compare_value) begin
            next_state.count_down = 1'b1;
            next_state.compare_timer = cur.compare_timer - 16'h0001;
          end else begin
            next_state.compare_timer = cur.compare_timer + 16'h0001;
          end
        end else if (cur.compare_timer == 16'h0000) begin
          next_state.count_down = 1'b0;
          next_state.compare_timer = 16'h0001;
        end else begin
          next_state.compare_timer = cur.compare_timer - 16'h0001;
        end
      end else if (mode == mode_pwm_edge && sec_match) begin
        next_state.compare_timer = 16'h0000;
      end else begin
        next_state.compare_timer = (cur.compare_timer + 16'h0001) & tmax;
      end
    end

    ////////////////////////////////////////////////////////////////////
    // Output behaviour per mode, evaluated every cycle
    unique case (compare_mode_t'(mode))
      mode_off: begin
        next_state.out_level = 1'b0;
      end
      mode_set_high: begin
        if (pri_match && !cur.shot_done) begin
          next_state.out_level = 1'b1;
          next_state.shot_done = 1'b1;
        end
      end
      mode_set_low: begin
        if (pri_match && !cur.shot_done) begin
          next_state.out_level = 1'b0;
          next_state.shot_done = 1'b1;
        end
      end
      mode_toggle: begin
        if (pri_match) begin
          next_state.out_level = ~cur.out_level;
        end
      end
      mode_dbl_single: begin
        if (!cur.shot_done && !cur.pulse_phase && pri_match) begin
          next_state.out_level = 1'b1;
          next_state.pulse_phase = 1'b1;
        end else if (!cur.shot_done && cur.pulse_phase && sec_match) begin
          next_state.out_level = 1'b0;
          next_state.pulse_phase = 1'b0;
          next_state.shot_done = 1'b1;
        end
      end
      mode_dbl_cont: begin
        if (!cur.pulse_phase && pri_match) begin
          next_state.out_level = 1'b1;
          next_state.pulse_phase = 1'b1;
        end else if (cur.pulse_phase && sec_match) begin
          next_state.out_level = 1'b0;
          next_state.pulse_phase = 1'b0;
        end
      end
      mode_pwm_edge: begin
        // High from period start until primary match
        if (cur.compare_control_one[fault0_bit]) begin
          next_state.out_level = 1'b0;
        end else if (sec_match) begin
          next_state.out_level = 1'b1;
        end else if (pri_match) begin
          next_state.out_level = 1'b0;
        end
      end
      mode_pwm_center: begin
        // High while timer is below primary value, mirrored both ways
        if (cur.compare_control_one[fault0_bit]) begin
          next_state.out_level = 1'b0;
        end else begin
          next_state.out_level =
            (cur.compare_timer < cur.primary_compare_value);
        end
      end
    endcase

    ////////////////////////////////////////////////////////////////////
    // Trigger status and fault flag
    if (cur.compare_control_one[trig_mode_bit] && sec_match
        && mode != mode_off) begin
      next_state.trigger_status = 1'b0;
    end
    if (!is_pwm(mode)) begin
      next_state.compare_control_one[fault0_bit] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // APB access, single wait state
    if (wr) begin
      next_state.ready = 1'b1;
      unique case (paddr)
        ctrl_one_addr: begin
          // Fault flag is not writable except to clear
          next_state.compare_control_one =
            {pwdata[15:5], cur.compare_control_one[fault0_bit]
             & pwdata[fault0_bit], pwdata[3:0]};
        end
        ctrl_two_addr: begin
          next_state.compare_control_two = pwdata[15:0];
          next_state.trigger_status = pwdata[trig_stat_bit];
        end
        primary_addr:   next_state.primary_compare_value = pwdata[15:0];
        secondary_addr: next_state.secondary_compare_value = pwdata[15:0];
        timer_addr:     next_state.compare_timer = pwdata[15:0] & tmax;
        irq_status_addr: begin
          next_state.irq_status = cur.irq_status & ~pwdata[irq_width-1:0];
        end
        irq_mask_addr:  next_state.irq_mask = pwdata[irq_width-1:0];
        default:        next_state.slverr = 1'b1;
      endcase
    end

    // A mode write restarts the single-shot sequencing
    if (mode_write) begin
      next_state.shot_done   = 1'b0;
      next_state.pulse_phase = 1'b0;
      next_state.count_down  = 1'b0;
      next_state.out_level   = (pwdata[2:0] == mode_set_low);
    end

    if (rd) begin
      next_state.ready = 1'b1;
      next_state.rdata = 32'h0000_0000;
      unique case (paddr)
        ctrl_one_addr: next_state.rdata = {16'h0000, cur.compare_control_one};
        ctrl_two_addr: begin
          next_state.rdata = {16'h0000, cur.compare_control_two};
          next_state.rdata[trig_stat_bit] = cur.trigger_status;
        end
        primary_addr:
          next_state.rdata = {16'h0000, cur.primary_compare_value};
        secondary_addr:
          next_state.rdata = {16'h0000, cur.secondary_compare_value};
        timer_addr:     next_state.rdata = {16'h0000, cur.compare_timer};
        irq_status_addr: next_state.rdata = {29'h0, cur.irq_status};
        irq_mask_addr:  next_state.rdata = {29'h0, cur.irq_mask};
        default:        next_state.slverr = 1'b1;
      endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Hardware sets win over a same-cycle clear
    if (fault_seen) begin
      next_state.compare_control_one[fault0_bit] = 1'b1;
      next_state.irq_status[irq_fault_bit] = 1'b1;
    end
    if (mode != mode_off && pri_match) begin
      next_state.irq_status[irq_match_bit] = 1'b1;
    end
    if (mode != mode_off && sec_match) begin
      next_state.irq_status[irq_second_bit] = 1'b1;
    end

    // Pin is low unless mapped to a remappable pin
    next_state.pin = output_pin_assigned & next_state.out_level;
    next_state.irq_line = |(next_state.irq_status & next_state.irq_mask);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur <= '0;
      cur.compare_control_one     <= ctrl_one_reset;
      cur.compare_control_two     <= ctrl_two_reset;
      cur.primary_compare_value   <= compare_reset;
      cur.secondary_compare_value <= compare_reset;
      cur.irq_mask                <= irq_mask_reset;
    end else begin
      cur <= next_state;
    end
  end

  assign prdata             = cur.rdata;
  assign pready             = cur.ready;
  assign pslverr            = cur.slverr;
  assign compare_output_pin = cur.pin;
  assign irq                = cur.irq_line;

  // Fault B is accepted for pin compatibility; only fault A and the group comparator set status
  logic unused_fault_b;
  assign unused_fault_b = fault_b_input;

endmodule // output_compare_channel

// ### hdl/ocmp_pkg.sv
// Register map, field layout and mode encodings of the compare channel
package ocmp_pkg;

  localparam logic [11:0] ctrl_one_addr    = 12'h000;
  localparam logic [11:0] ctrl_two_addr    = 12'h004;
  localparam logic [11:0] primary_addr     = 12'h008;
  localparam logic [11:0] secondary_addr   = 12'h00c;
  localparam logic [11:0] timer_addr       = 12'h010;
  localparam logic [11:0] irq_status_addr  = 12'h014;
  localparam logic [11:0] irq_mask_addr    = 12'h018;

  localparam int mode_lsb       = 0;
  localparam int trig_mode_bit  = 3;
  localparam int fault0_bit     = 4;
  localparam int fault_en_bit   = 5;
  localparam int timer_en_bit   = 6;
  localparam int trig_stat_bit  = 6;

  localparam int irq_match_bit  = 0;
  localparam int irq_second_bit = 1;
  localparam int irq_fault_bit  = 2;
  localparam int irq_width      = 3;

  localparam logic [15:0] ctrl_one_reset  = 16'h0000;
  localparam logic [15:0] ctrl_two_reset  = 16'h0000;
  localparam logic [15:0] compare_reset   = 16'h0000;
  localparam logic [2:0]  irq_mask_reset  = 3'h0;

  typedef enum logic [2:0] {
    mode_off        = 3'b000,
    mode_set_high   = 3'b001,
    mode_set_low    = 3'b010,
    mode_toggle     = 3'b011,
    mode_dbl_single = 3'b100,
    mode_dbl_cont   = 3'b101,
    mode_pwm_edge   = 3'b110,
    mode_pwm_center = 3'b111
  } compare_mode_t;

endpackage

// ### testbench/ocmp_props.sv
// Bus and pin assertions for the output compare channel
`timescale 1ns/1ps
module ocmp_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        output_pin_assigned,
  input wire logic        compare_output_pin,
  input wire logic        irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  answer_time_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  ready_cause_a: assert property (pready |-> psel && penable)
    else $error("pready without a transfer");
  err_pairing_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (
    psel && penable && !pready && paddr > 12'h018 |=> pslverr)
    else $error("unmapped address not refused");
  upper_zero_a: assert property (
    pready && !pwrite && !pslverr |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  reset_quiet_a: assert property (
    $fell(rst) |-> !pready && !irq && !compare_output_pin)
    else $error("outputs active after reset");
  pin_gate_a: assert property (
    !output_pin_assigned [*2] |-> !compare_output_pin)
    else $error("pin driven while unassigned");
endmodule // ocmp_props

bind output_compare_channel ocmp_props i_ocmp_props (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .output_pin_assigned(output_pin_assigned),
  .compare_output_pin(compare_output_pin), .irq(irq));

// ### testbench/ocmp_load.sv
// External load on the compare pin with an overload sense line
`timescale 1ns/1ps
module ocmp_load (
  // Clock
  input wire logic clk_sys,
  // Pin side
  input wire logic compare_output_pin,
  input wire logic overload_cmd,
  output logic       fault_a_input,
  output logic [7:0] rises
);
  logic [7:0] count = 8'h00;
  logic       last  = 1'b0;
  logic       sense = 1'b0;

  // Sense circuit reports a cycle late, like a real comparator
  always @(posedge clk_sys) begin
    sense <= overload_cmd;
    last  <= compare_output_pin;
    if (compare_output_pin && !last) count <= count + 8'h01;
  end
  assign fault_a_input = sense;
  assign rises         = count;
endmodule // ocmp_load

// ### testbench/output_compare_channel_tb.sv
// Self-checking bench for the output compare channel
`timescale 1ns/1ps
module output_compare_channel_tb;
  import ocmp_pkg::*;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic        fault_a_input, fault_b_input, output_pin_assigned;
  logic        fault_pin_assigned, compare_output_pin, overload_cmd, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0]  comparator_out;
  logic [7:0]  rises, r0;
  logic [6:0]  ent;
  logic [4:0]  e;
  int          n_mismatch = 0, comparisons = 0, cyc = 0, p, trig;
  // Fault cases: mode, source, pin assigned, fault expected
  logic [6:0]  tbl [5] = '{7'b110_00_11, 7'b011_00_10, 7'b111_01_11,
                           7'b110_10_10, 7'b111_00_00};

  output_compare_channel i_output_compare_channel (.clk_sys(clk_sys),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_a_input(fault_a_input),
    .fault_b_input(fault_b_input), .comparator_out(comparator_out),
    .output_pin_assigned(output_pin_assigned),
    .fault_pin_assigned(fault_pin_assigned),
    .compare_output_pin(compare_output_pin), .irq(irq));
  ocmp_load i_ocmp_load (.clk_sys(clk_sys), .rises(rises),
    .compare_output_pin(compare_output_pin), .overload_cmd(overload_cmd),
    .fault_a_input(fault_a_input));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Idle cycle at the end keeps psel from being driven twice at one edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for pready
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // Pin at init, mid and end of two timer passes
  function automatic logic [4:0] pin_plan(input int m);
    case (m)
      1: return 5'b01111;
      2: return 5'b10000;
      3: return 5'b01100;
      4: return 5'b01000;
      5: return 5'b01010;
      default: return 5'b00000;
    endcase
  endfunction

  function automatic int rise_plan(input int m);
    return (m == 5) ? 2 : (m == 0 || m == 2) ? 0 : 1;
  endfunction

  task automatic stop_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    {psel, penable, pwrite, overload_cmd, fault_b_input} = 5'h00;
    {paddr, pwdata, comparator_out} = '0;
    output_pin_assigned = 1'b0;
    fault_pin_assigned = 1'b1;
    rst = 1'b1;
    void'($urandom(50));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    output_pin_assigned <= 1'b1;
    rd(ctrl_one_addr, 32'h0);
    rd(irq_mask_addr, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(32'(err), 32'h1);
    wr(irq_mask_addr, 32'h1);
    for (int m = 0; m < 6; m++) begin
      p = 8 + $urandom % 32;
      trig = $urandom % 2;
      e = pin_plan(m);
      wr(primary_addr, 32'(p));
      wr(secondary_addr, 32'(p + 30));
      wr(ctrl_two_addr, 32'h40);
      wr(timer_addr, 32'h0);
      wr(ctrl_one_addr, 32'(32'h40 | trig << 3 | m));
      @(posedge clk_sys);
      chk(32'(compare_output_pin), 32'(e[4]));
      r0 = rises;
      for (int k = 3; k >= 0; k--) begin
        if (k == 1) wr(timer_addr, 32'h0);
        repeat ((k % 2) ? p + 13 : 30) @(posedge clk_sys);
        chk(32'(compare_output_pin), 32'(e[k]));
      end
      chk(32'(rises - r0), 32'(rise_plan(m)));
      output_pin_assigned <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(32'(compare_output_pin), 32'h0);
      output_pin_assigned <= 1'b1;
      rd(ctrl_two_addr, (trig != 0 && m != 0) ? 32'h0 : 32'h40);
      chk(32'(irq), 32'(m != 0));
      wr(irq_status_addr, 32'h7);
      @(posedge clk_sys);
      chk(32'(irq), 32'h0);
    end
    for (int k = 0; k < 5; k++) begin
      ent = tbl[k];
      fault_pin_assigned <= ent[1];
      fault_b_input <= 1'($urandom % 2);
      wr(irq_status_addr, 32'h7);
      wr(ctrl_one_addr, 32'h60 | 32'(ent[6:4]));
      overload_cmd <= (ent[3:2] == 2'd0);
      comparator_out <= {1'b0, ent[3:2]};
      repeat (4) @(posedge clk_sys);
      overload_cmd <= 1'b0;
      comparator_out <= 3'h0;
      repeat (2) @(posedge clk_sys);
      rd(ctrl_one_addr, 32'h60 | 32'(ent[6:4]) | 32'(ent[0]) << 4);
      apb(1'b0, irq_status_addr, 32'h0);
      chk(32'(q[irq_fault_bit]), 32'(ent[0]));
    end
    // Edge then center PWM: one rise a period, counted over whole periods
    wr(primary_addr, 32'h4);
    wr(secondary_addr, 32'h9);
    wr(timer_addr, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(ctrl_one_addr, 32'h46 + 32'(k));
      repeat (30) @(posedge clk_sys);
      r0 = rises;
      repeat (k ? 54 : 50) @(posedge clk_sys);
      chk(32'(rises - r0), k ? 32'h3 : 32'h5);
    end
    stop_test();
  end
endmodule // output_compare_channel_tb
